// *** common/sewp_map.svh ***
`ifndef SEWP_MAP_SVH
`define SEWP_MAP_SVH

// Device address window for the main array.
`define SEWP_DEV_ADDR_LO   8'hA8
`define SEWP_DEV_ADDR_HI   8'hAF
// Field positions inside the device address byte.
`define SEWP_RW_BIT        0
`define SEWP_HI_ADDR_MSB   2
`define SEWP_HI_ADDR_LSB   1
// Field positions inside the 10-bit word pointer.
`define SEWP_BLOCK_MSB     9
`define SEWP_BLOCK_LSB     7
`define SEWP_PAGE_MSB      6
`define SEWP_PAGE_LSB      4
`define SEWP_BYTE_MSB      3
`define SEWP_BYTE_LSB      0
// Page geometry and byte framing.
`define SEWP_PAGE_BYTES    5'h10
`define SEWP_ACK_BIT_IDX   4'h8
`define SEWP_LAST_DATA_IDX 4'h7
// Reset values.
`define SEWP_PTR_RST       10'h000
`define SEWP_CNT_RST       5'h00
// Self-timed cycle: the time in ns and the clock period in ns.
`define SEWP_EW_TIME_NS    32'h004C4B40
`define SEWP_CLK_NS        32'h00000005
`define SEWP_EW_CYCLES     ((`SEWP_EW_TIME_NS / `SEWP_CLK_NS) - 32'h1)

`endif

// *** common/sewp_pkg.sv ***
package sewp_pkg;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_DEVADDR,
    PH_WORDADDR,
    PH_DATA,
    PH_IGNORE
  } sewp_phase_t;

  typedef logic [9:0] sewp_addr_t;
  typedef logic [7:0] sewp_byte_t;

endpackage : sewp_pkg

// *** rtl/sewp_bit_capture.sv ***
// Samples the data line on each rising edge of the link clock. The held bit
// stays stable for a whole link period, so the system domain reads it only
// after it has seen the synchronised clock rise.
module sewp_bit_capture (
  input  wire logic scl_i,  // Link clock from the bus master.
  input  wire logic sda_i,  // Serial data line level.
  output logic      bit_o   // Bit taken at the latest rising edge.
);

  always_ff @(posedge scl_i) begin
    bit_o <= sda_i;
  end

endmodule : sewp_bit_capture

// *** rtl/sewp_fifo2.sv ***
module sewp_fifo2 #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 2
) (
  input  wire logic             mclk_i,       // System clock.
  input  wire logic             srst_i,       // Synchronous reset.
  input  wire logic             in_valid_i,   // Entry offered.
  output logic                  in_ready_o,   // Room for an entry.
  input  wire logic [WIDTH-1:0] in_data_i,    // Entry contents.
  output logic                  out_valid_o,  // Entry available.
  input  wire logic             out_ready_i,  // Drain accepts entry.
  output logic      [WIDTH-1:0] out_data_o    // Oldest entry.
);

  localparam int PW = $clog2(DEPTH);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("sewp_fifo2: DEPTH must be a power of two of at least 2");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW:0]      count_reg;

  wire push = in_valid_i && in_ready_o;
  wire pop  = out_valid_o && out_ready_i;

  assign in_ready_o  = count_reg != (PW+1)'(DEPTH);
  assign out_valid_o = count_reg != '0;
  assign out_data_o  = mem_reg[rd_ptr_reg];

  always_ff @(posedge mclk_i) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_i;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + PW'(push);
      rd_ptr_reg <= rd_ptr_reg + PW'(pop);
      count_reg  <= count_reg + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule : sewp_fifo2

// *** rtl/sewp_write_port.sv ***
`include "sewp_map.svh"

// Functional notes
// - Acknowledge device addresses A8h to AFh; bits 2:1 give pointer bits.
// - Address byte bit 0 high means read, low means write.
// - Write protect pin high refuses every write.
// - Next byte after write address is low word address, acknowledged.
// - Word address alone only loads the pointer, programs nothing.
// - Each data byte is acknowledged and stored at the current address.
// - Only four low pointer bits increment, wrapping within the page.
// - At most 16 data bytes per transfer, programmed in one cycle.
// - Seventeenth data byte is not acknowledged; transfer discarded.
// - STOP ends a write and starts the self-timed cycle.
// - During the cycle the device does not acknowledge its address.
// - All bus input is ignored until the cycle has completed.
// - The self-timed cycle finishes in less than 5 ms; a stalled array can hold it open longer.
// - Pointer splits into block 3 bits, page 3 bits, byte 4 bits.
// - Array is 8 blocks of 128 bytes, each 8 pages of 16 bytes.
// - Every byte travels most significant bit first.
module sewp_write_port
  import sewp_pkg::*;
#(
  parameter int unsigned EW_CYCLES  = `SEWP_EW_CYCLES,
  parameter int          FIFO_DEPTH = 2
) (
  input  wire logic       mclk_i,       // System clock, 200 MHz.
  input  wire logic       srst_i,       // Synchronous reset, active high.
  input  wire logic       scl_i,        // Serial clock pin, link clock.
  input  wire logic       sda_i,        // Serial data pin level.
  output logic            sda_o,        // Serial data drive value.
  output logic            sda_oe_o,     // High while pulling data low.
  input  wire logic       wp_i,         // Write protect pin, active high.
  output logic            wr_valid_o,   // Array write offered.
  input  wire logic       wr_ready_i,   // Array accepts the write.
  output sewp_addr_t      wr_addr_o,    // Array write address.
  output sewp_byte_t      wr_data_o,    // Array write data.
  output logic [2:0]      wr_block_o,   // Block of the write address.
  output logic [2:0]      wr_page_o,    // Page of the write address.
  output logic [3:0]      wr_byte_o,    // Byte of the write address.
  output sewp_addr_t      ptr_o,        // Internal address pointer.
  output logic            busy_o        // Self-timed cycle running.
);

  if (EW_CYCLES < 1 || FIFO_DEPTH != 2) begin : g_bad_param
    $error("sewp_write_port: EW_CYCLES >= 1 and FIFO_DEPTH == 2 needed");
  end

  function automatic logic [2:0] block_of(input sewp_addr_t a);
    return a[`SEWP_BLOCK_MSB:`SEWP_BLOCK_LSB];
  endfunction : block_of

  function automatic logic [2:0] page_of(input sewp_addr_t a);
    return a[`SEWP_PAGE_MSB:`SEWP_PAGE_LSB];
  endfunction : page_of

  function automatic logic [3:0] byte_of(input sewp_addr_t a);
    return a[`SEWP_BYTE_MSB:`SEWP_BYTE_LSB];
  endfunction : byte_of

  // Pin synchronisers; stage 0 feeds only stage 1.
  logic [1:0]  scl_sync_reg;
  logic [1:0]  sda_sync_reg;
  logic [1:0]  wp_sync_reg;
  logic        scl_prev_reg;
  logic        sda_prev_reg;
  logic        link_bit;

  sewp_phase_t phase_reg;
  sewp_phase_t phase_next;
  logic [3:0]  bit_cnt_reg;
  logic [7:0]  shift_reg;
  sewp_addr_t  ptr_reg;
  logic [4:0]  data_cnt_reg;
  logic        ack_pend_reg;
  logic        ack_on_reg;
  sewp_byte_t  page_data_reg [16];
  logic [3:0]  page_off_reg  [16];
  logic [5:0]  base_reg;
  logic        busy_reg;
  logic [31:0] ew_timer_reg;
  logic [4:0]  drain_idx_reg;
  logic [4:0]  drain_cnt_reg;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      scl_sync_reg <= 2'h3;
      sda_sync_reg <= 2'h3;
      wp_sync_reg  <= 2'h3;
      scl_prev_reg <= 1'h1;
      sda_prev_reg <= 1'h1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[0], scl_i};
      sda_sync_reg <= {sda_sync_reg[0], sda_i};
      wp_sync_reg  <= {wp_sync_reg[0], wp_i};
      scl_prev_reg <= scl_sync_reg[1];
      sda_prev_reg <= sda_sync_reg[1];
    end
  end

  sewp_bit_capture u_capture (
    .scl_i (scl_i),
    .sda_i (sda_i),
    .bit_o (link_bit)
  );

  wire scl_s     = scl_sync_reg[1];
  wire sda_s     = sda_sync_reg[1];
  wire wp_s      = wp_sync_reg[1];
  wire scl_rise  = scl_s && !scl_prev_reg;
  wire scl_fall  = !scl_s && scl_prev_reg;
  wire scl_hold  = scl_s && scl_prev_reg;
  wire start_det = scl_hold && sda_prev_reg && !sda_s;
  wire stop_det  = scl_hold && !sda_prev_reg && sda_s;

  wire rx_active = phase_reg == PH_DEVADDR || phase_reg == PH_WORDADDR ||
                   phase_reg == PH_DATA;
  wire rx_shift  = scl_rise && rx_active &&
                   bit_cnt_reg != `SEWP_ACK_BIT_IDX;
  wire byte_done = rx_shift && bit_cnt_reg == `SEWP_LAST_DATA_IDX;
  wire [7:0] rx_byte = {shift_reg[6:0], link_bit};

  wire dev_match = rx_byte >= `SEWP_DEV_ADDR_LO &&
                   rx_byte <= `SEWP_DEV_ADDR_HI;
  wire is_read   = rx_byte[`SEWP_RW_BIT];
  wire page_full = data_cnt_reg == `SEWP_PAGE_BYTES;
  wire at_dev    = phase_reg == PH_DEVADDR;
  wire at_word   = phase_reg == PH_WORDADDR;
  wire at_data   = phase_reg == PH_DATA;
  wire data_take = byte_done && at_data && !page_full && !wp_s;
  wire addr_wr   = byte_done && at_dev && dev_match && !is_read;
  wire commit    = stop_det && at_data && data_cnt_reg != `SEWP_CNT_RST &&
                   !wp_s && !busy_reg;

  wire ack_want  = (at_dev && dev_match && !busy_reg) ||
                   at_word ||
                   (at_data && !page_full && !wp_s);

  always_comb begin
    phase_next = phase_reg;
    if (start_det) begin
      phase_next = busy_reg ? PH_IGNORE : PH_DEVADDR;
    end else if (stop_det) begin
      phase_next = PH_IDLE;
    end else if (byte_done) begin
      case (phase_reg)
        PH_DEVADDR: begin
          // Read sequencing lives outside this port.
          if (!dev_match || is_read) begin
            phase_next = PH_IGNORE;
          end else begin
            phase_next = PH_WORDADDR;
          end
        end
        PH_WORDADDR: begin
          phase_next = PH_DATA;
        end
        PH_DATA: begin
          if (page_full || wp_s) begin
            phase_next = PH_IGNORE;
          end
        end
        default: begin
          phase_next = phase_reg;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      phase_reg <= PH_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i || start_det || stop_det) begin
      bit_cnt_reg <= 4'h0;
    end else if (scl_rise && rx_active) begin
      bit_cnt_reg <= (bit_cnt_reg == `SEWP_ACK_BIT_IDX) ? 4'h0 :
                     bit_cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      shift_reg <= 8'h00;
    end else if (rx_shift) begin
      shift_reg <= rx_byte;
    end
  end

  // The acknowledge is driven from the fall after the eighth bit until the
  // fall after the ninth, so the data line never moves while clock is high.
  always_ff @(posedge mclk_i) begin
    if (srst_i || start_det || stop_det) begin
      ack_pend_reg <= 1'h0;
      ack_on_reg   <= 1'h0;
    end else if (byte_done) begin
      ack_pend_reg <= ack_want;
    end else if (scl_fall) begin
      ack_on_reg   <= ack_pend_reg;
      ack_pend_reg <= 1'h0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ptr_reg      <= `SEWP_PTR_RST;
      data_cnt_reg <= `SEWP_CNT_RST;
      base_reg     <= 6'h00;
    end else if (addr_wr) begin
      ptr_reg[9:8] <= rx_byte[`SEWP_HI_ADDR_MSB:`SEWP_HI_ADDR_LSB];
    end else if (byte_done && at_word) begin
      ptr_reg[7:0] <= rx_byte;
      base_reg     <= {ptr_reg[9:8], rx_byte[7:4]};
      data_cnt_reg <= `SEWP_CNT_RST;
    end else if (data_take) begin
      ptr_reg[3:0] <= ptr_reg[3:0] + 4'h1;
      data_cnt_reg <= data_cnt_reg + 5'h01;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (data_take) begin
      page_data_reg[data_cnt_reg[3:0]] <= rx_byte;
      page_off_reg[data_cnt_reg[3:0]]  <= byte_of(ptr_reg);
    end
  end

  // The page buffer drains through the two-entry buffer while the timer
  // runs; a stalled array holds the cycle open until every byte is taken.
  logic        fifo_in_ready;
  logic [17:0] fifo_out;
  wire         drain_go  = busy_reg && drain_idx_reg != drain_cnt_reg;
  wire         drain_end = !drain_go && !wr_valid_o;
  wire [17:0]  drain_word = {base_reg, page_off_reg[drain_idx_reg[3:0]],
                             page_data_reg[drain_idx_reg[3:0]]};

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      busy_reg      <= 1'h0;
      ew_timer_reg  <= 32'h0;
      drain_idx_reg <= `SEWP_CNT_RST;
      drain_cnt_reg <= `SEWP_CNT_RST;
    end else if (commit) begin
      busy_reg      <= 1'h1;
      ew_timer_reg  <= 32'(EW_CYCLES - 1);
      drain_idx_reg <= `SEWP_CNT_RST;
      drain_cnt_reg <= data_cnt_reg;
    end else if (busy_reg) begin
      if (ew_timer_reg != 32'h0) begin
        ew_timer_reg <= ew_timer_reg - 32'h1;
      end else if (drain_end) begin
        busy_reg <= 1'h0;
      end
      if (drain_go && fifo_in_ready) begin
        drain_idx_reg <= drain_idx_reg + 5'h01;
      end
    end
  end

  sewp_fifo2 #(
    .WIDTH (18),
    .DEPTH (FIFO_DEPTH)
  ) u_buf (
    .mclk_i      (mclk_i),
    .srst_i      (srst_i),
    .in_valid_i  (drain_go),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (drain_word),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (fifo_out)
  );

  assign wr_addr_o  = fifo_out[17:8];
  assign wr_data_o  = fifo_out[7:0];
  assign wr_block_o = block_of(wr_addr_o);
  assign wr_page_o  = page_of(wr_addr_o);
  assign wr_byte_o  = byte_of(wr_addr_o);
  assign sda_o      = 1'h0;
  assign sda_oe_o   = ack_on_reg;
  assign ptr_o      = ptr_reg;
  assign busy_o     = busy_reg;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);

  chk_addr_match_ack: assert property (
    byte_done && at_dev && dev_match && !busy_reg |=>
      ack_pend_reg ##[1:40] ack_on_reg)
    else $error("matching device address not acknowledged");

  chk_read_no_word: assert property (
    byte_done && at_dev && is_read |=> phase_reg == PH_IGNORE)
    else $error("read request entered write sequence");

  chk_wp_no_write: assert property (
    wp_s && stop_det && !busy_reg |=> !busy_reg)
    else $error("write cycle started while write protected");

  chk_word_load: assert property (
    byte_done && at_word |=>
      ptr_reg[7:0] == $past(rx_byte) && ack_pend_reg &&
      phase_reg == PH_DATA)
    else $error("word address not loaded or not acknowledged");

  chk_addr_only: assert property (
    stop_det && at_data && data_cnt_reg == `SEWP_CNT_RST && !busy_reg
      |=> !busy_reg)
    else $error("address-only write started a cycle");

  chk_data_store: assert property (
    data_take |=>
      page_data_reg[$past(data_cnt_reg[3:0])] == $past(rx_byte) &&
      ack_pend_reg)
    else $error("data byte not stored or not acknowledged");

  chk_ptr_wrap: assert property (
    data_take |=> ptr_reg[9:4] == $past(ptr_reg[9:4]) &&
      ptr_reg[3:0] == $past(ptr_reg[3:0]) + 4'h1)
    else $error("pointer increment left the page");

  chk_page_limit: assert property (
    data_cnt_reg <= `SEWP_PAGE_BYTES && drain_cnt_reg <= `SEWP_PAGE_BYTES)
    else $error("page buffer count above page size");

  chk_over_nack: assert property (
    byte_done && at_data && page_full |=>
      !ack_pend_reg && phase_reg == PH_IGNORE ##1 !busy_reg)
    else $error("overlong page write was accepted");

  chk_stop_start: assert property (
    commit |=> busy_reg && drain_cnt_reg == $past(data_cnt_reg) &&
      ew_timer_reg == 32'(EW_CYCLES - 1))
    else $error("stop did not start the write cycle");

  chk_busy_quiet: assert property (
    busy_reg |-> !ack_on_reg && !ack_pend_reg)
    else $error("device acknowledged during write cycle");

  chk_busy_ignore: assert property (
    busy_reg && start_det |=> phase_reg == PH_IGNORE)
    else $error("bus input taken during write cycle");

  chk_ew_bound: assert property (
    busy_reg |-> ew_timer_reg < EW_CYCLES)
    else $error("write cycle timer beyond its bound");

  chk_foreign_idle: assert property (
    byte_done && at_dev && !dev_match |=>
      (phase_reg == PH_IGNORE && !ack_pend_reg) [*3])
    else $error("foreign address not ignored");

endmodule : sewp_write_port

// *** tb/sewp_master_model.sv ***
module sewp_master_model (
  input  wire logic sda_i,   // Resolved data line.
  output logic      scl_o,   // Link clock, idle high.
  output logic      pull_o   // High while pulling data low.
);
  timeunit 1ns;
  timeprecision 100ps;

  localparam int HALF = 16;

  initial begin
    scl_o  = 1'b1;
    pull_o = 1'b0;
  end

  // Each bit takes one 32 ns link period: data moves 4 ns after the fall,
  // the clock stays low for 20 ns and high for 12 ns, which leaves the slave
  // time to synchronise the fall and drive its acknowledge.
  task automatic clk_bit(input logic b, output logic s);
    pull_o = ~b;
    #(HALF);
    scl_o = 1'h1;
    #6;
    s = sda_i;
    #6;
    scl_o = 1'h0;
    #4;
  endtask : clk_bit

  task automatic start;
    pull_o = 1'b0;
    scl_o  = 1'b1;
    #(HALF);
    pull_o = 1'b1;
    #(HALF);
    scl_o = 1'b0;
    #8;
  endtask : start

  task automatic stop;
    pull_o = 1'b1;
    #(HALF);
    scl_o = 1'b1;
    #(HALF);
    pull_o = 1'b0;
    #(2 * HALF);
  endtask : stop

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(b[i], s);
    end
    clk_bit(1'b1, s);
    ack = ~s;
  endtask : send_byte
endmodule : sewp_master_model

// *** tb/sewp_write_port_tb.sv ***
module sewp_write_port_tb;
  import sewp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int unsigned EW = 200;

  logic       mclk = 1'b0;
  logic       srst = 1'b1;
  logic       wp = 1'b0;
  logic       wr_ready = 1'b0;
  logic       scl;
  logic       pull;
  logic       sda;
  logic       sda_drv;
  logic       sda_oe;
  logic       wr_valid;
  sewp_addr_t wr_addr;
  sewp_byte_t wr_data;
  logic [2:0] wr_block;
  logic [2:0] wr_page;
  logic [3:0] wr_byte;
  sewp_addr_t ptr;
  logic       busy;
  logic [17:0] exp_q[$];
  int         seed = 14;
  int         fail_count = 0;
  int         checks_done = 0;
  int         busy_run = 0;
  int         busy_last = 0;

  always #2.5 mclk = ~mclk;

  // Open-drain data line with a pull-up.
  assign sda = ~(pull | (sda_oe & ~sda_drv));

  sewp_master_model master (
    .sda_i  (sda),
    .scl_o  (scl),
    .pull_o (pull)
  );

  sewp_write_port #(.EW_CYCLES(EW), .FIFO_DEPTH(2)) dut (
    .mclk_i     (mclk),
    .srst_i     (srst),
    .scl_i      (scl),
    .sda_i      (sda),
    .sda_o      (sda_drv),
    .sda_oe_o   (sda_oe),
    .wp_i       (wp),
    .wr_valid_o (wr_valid),
    .wr_ready_i (wr_ready),
    .wr_addr_o  (wr_addr),
    .wr_data_o  (wr_data),
    .wr_block_o (wr_block),
    .wr_page_o  (wr_page),
    .wr_byte_o  (wr_byte),
    .ptr_o      (ptr),
    .busy_o     (busy)
  );

  task automatic stop_test;
    $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [17:0] e, input logic [17:0] g);
    checks_done++;
    if (e !== g) begin
      fail_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk

  // The array side stalls at random.
  always @(posedge mclk) begin
    #1;
    wr_ready = 1'($random(seed));
  end

  // Length of the latest self-timed cycle, counted in clock edges.
  always @(posedge mclk) begin
    if (busy === 1'h1) begin
      busy_run++;
    end else if (busy_run != 0) begin
      busy_last = busy_run;
      busy_run  = 0;
    end
  end

  always @(posedge mclk) begin
    if (!srst && wr_valid && wr_ready) begin
      chk({8'h00, wr_addr}, {8'h00, wr_block, wr_page, wr_byte});
      if (exp_q.size() == 0) begin
        chk({18{1'bx}}, {wr_addr, wr_data});
      end else begin
        chk(exp_q.pop_front(), {wr_addr, wr_data});
      end
    end
  end

  task automatic xfer(input logic [7:0] b, input logic exp_ack);
    logic a;
    master.send_byte(b, a);
    chk({17'h0, exp_ack}, {17'h0, a});
  endtask : xfer

  task automatic wait_idle;
    int k;
    k = 0;
    while ((busy !== 1'b0 || exp_q.size() != 0) && k < 20000) begin
      @(posedge mclk);
      k++;
    end
    if (k >= 20000) begin
      fail_count++;
      stop_test();
    end
    repeat (20) @(posedge mclk);
  endtask : wait_idle

  task automatic page_write(input logic [1:0] blk, input logic [7:0] word,
                            input int cnt);
    logic [7:0] d;
    master.start();
    xfer({5'h15, blk, 1'b0}, 1'b1);
    xfer(word, 1'b1);
    for (int i = 0; i < cnt; i++) begin
      d = 8'($random(seed));
      xfer(d, i < 16 && !wp);
      if (cnt <= 16 && !wp) begin
        exp_q.push_back({blk, word[7:4], word[3:0] + 4'(i), d});
      end
    end
    master.stop();
    repeat (10) @(posedge mclk);
    if (cnt <= 16 && !wp) begin
      chk(18'h1, {17'h0, busy});
    end
  endtask : page_write

  initial begin
    #400000;
    fail_count++;
    stop_test();
  end

  initial begin
    logic [7:0] a;
    logic       hit;
    repeat (16) @(posedge mclk);
    #1;
    srst = 1'b0;
    repeat (4) @(posedge mclk);
    chk(18'h0, {8'h00, ptr});
    for (int k = 0; k < 16; k++) begin
      a = 8'hA0 + 8'(k);
      hit = a >= 8'hA8 && a <= 8'hAF;
      master.start();
      xfer(a, hit);
      xfer(8'h5A, hit && !a[0]);
      master.stop();
      wait_idle();
      if (hit && !a[0]) begin
        chk({8'h00, a[2:1], 8'h5A}, {8'h00, ptr});
      end
    end
    $display("test address_decode done");
    page_write(2'h1, 8'h3C, 1);
    wait_idle();
    chk(18'h1, {17'h0, busy_last >= EW && busy_last <= EW + 20});
    $display("test byte_write done");
    page_write(2'h2, 8'h65, 16);
    master.start();
    xfer(8'hA8, 1'b0);
    xfer(8'h00, 1'b0);
    master.stop();
    wait_idle();
    $display("test page_wrap_busy done");
    #1;
    wp = 1'h1;
    wait_idle();
    page_write(2'h3, 8'h40, 2);
    #1;
    wp = 1'h0;
    repeat (300) @(posedge mclk);
    chk(18'h0, {17'h0, busy});
    $display("test write_protect done");
    page_write(2'h0, 8'h80, 17);
    repeat (300) @(posedge mclk);
    chk(18'h0, {17'h0, busy});
    chk(18'h0, 18'(exp_q.size()));
    $display("test overlong_page done");
    stop_test();
  end
endmodule : sewp_write_port_tb
